// ==== hdl/raw_readout.sv ====
// Command decoder, coefficient store and raw-mode frame output
`timescale 1ns/10ps
module raw_readout (
  input wire logic clk,
  input wire logic srst,
  input wire raw_readout_pkg::cmd_pair_t cmd_in,
  input wire raw_readout_pkg::meas_t meas_in,
  input wire logic corr_valid,
  input wire logic [7:0] corr_data,
  output raw_readout_pkg::byte_out_t byte_out,
  input wire logic byte_ready,
  output raw_readout_pkg::mode_t mode,
  output logic raw_active,
  output logic [23:0] customer_id,
  output logic [14:0] gain_b,
  output logic [7:0] gain_t,
  output logic frame_dropped
);
  import raw_readout_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    mode_t mode;
    logic [7:0] customer_id_byte0;
    logic [7:0] customer_id_byte1;
    logic [7:0] customer_id_byte2;
    logic [14:0] gain_b;
    logic [7:0] gain_t;
    logic [1:0] idx;
    logic busy;
    logic [BRIDGE_W-1:0] bridge;
    logic [TEMP_SENT_W-1:0] temp;
    byte_out_t out;
    logic dropped;
  } state_t;

  state_t s_reg, s_next;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic push_valid;
  logic [7:0] push_data;
  logic raw_stream;
  logic out_take;

  function automatic logic [7:0] frame_byte(input logic [1:0] idx,
                                            input logic [BRIDGE_W-1:0] br,
                                            input logic [TEMP_SENT_W-1:0] tp);
    case (idx)
      2'h0: frame_byte = {2'b00, br[BRIDGE_W-1:8]};
      2'h1: frame_byte = br[7:0];
      default: frame_byte = tp;
    endcase
  endfunction

  // Uncorrected data streams only with both gains at unity
  assign raw_stream = (s_reg.mode == MODE_RAW) && (s_reg.gain_b == GAIN_B_UNITY)
    && (s_reg.gain_t == GAIN_T_UNITY);

  // ****************************************
  // Byte source into the FIFO
  // ****************************************
  always_comb begin
    push_valid = 1'b0;
    push_data = 8'h00;
    if (s_reg.busy) begin
      push_valid = 1'b1;
      push_data = frame_byte(s_reg.idx, s_reg.bridge, s_reg.temp);
    end else if (s_reg.mode != MODE_RAW) begin
      push_valid = corr_valid;
      push_data = corr_data;
    end
  end

  byte_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(out_take),
    .out_data(fifo_out_data)
  );

  // Output register drains FIFO when empty or accepted
  assign out_take = !s_reg.out.valid || byte_ready;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.dropped = 1'b0;
    // Configuration changes only via the serial command pairs
    if (cmd_in.valid) begin
      case (s_reg.mode)
        MODE_NORMAL: begin
          if (cmd_in.cmd == CMD_ENTER_COMMAND_MODE_CMD && cmd_in.dat == DAT_ENTER_COMMAND_MODE_CMD) begin
            s_next.mode = MODE_COMMAND;
          end
        end
        default: begin
          if (cmd_in.cmd == CMD_MODE && cmd_in.dat == DAT_ENTER_NORMAL_MODE_CMD) begin
            s_next.mode = MODE_NORMAL;
          end else if (cmd_in.cmd == CMD_MODE && cmd_in.dat == DAT_ENTER_RAW_MODE_CMD &&
                       s_reg.mode == MODE_COMMAND) begin
            s_next.mode = MODE_RAW;
          end else if (cmd_in.cmd == CMD_ENTER_COMMAND_MODE_CMD && cmd_in.dat == DAT_ENTER_COMMAND_MODE_CMD) begin
            s_next.mode = MODE_COMMAND;
          end else begin
            case (cmd_in.cmd)
              CMD_GAIN_B_HI: s_next.gain_b[14:8] = cmd_in.dat[6:0];
              CMD_GAIN_B_LO: s_next.gain_b[7:0] = cmd_in.dat;
              CMD_GAIN_T: s_next.gain_t = cmd_in.dat;
              CMD_CUSTOMER_ID_BYTE0: s_next.customer_id_byte0 = cmd_in.dat;
              CMD_CUSTOMER_ID_BYTE1: s_next.customer_id_byte1 = cmd_in.dat;
              CMD_CUSTOMER_ID_BYTE2: s_next.customer_id_byte2 = cmd_in.dat;
              default: ;
            endcase
          end
        end
      endcase
    end
    // Frame advance: FIFO back-pressure stalls the sequencer
    if (s_reg.busy && fifo_in_ready) begin
      if (s_reg.idx == FRAME_LAST) begin
        s_next.busy = 1'b0;
        s_next.idx = 2'h0;
      end else begin
        s_next.idx = s_reg.idx + 2'h1;
      end
    end
    // A measurement during a frame is dropped, not merged into it
    if (meas_in.valid && raw_stream) begin
      if (!s_reg.busy) begin
        s_next.busy = 1'b1;
        s_next.idx = 2'h0;
        s_next.bridge = meas_in.bridge;
        s_next.temp = meas_in.temp[TEMP_SENT_W-1:0];
      end else begin
        s_next.dropped = 1'b1;
      end
    end
    if (s_reg.mode == MODE_RAW && s_next.mode != MODE_RAW) begin
      s_next.busy = 1'b0;
      s_next.idx = 2'h0;
    end
    if (out_take) begin
      s_next.out.valid = fifo_out_valid;
      s_next.out.data = fifo_out_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.mode <= MODE_NORMAL;
      s_reg.gain_b <= GAIN_B_RESET;
      s_reg.gain_t <= GAIN_T_RESET;
      s_reg.customer_id_byte0 <= CUST_ID_RESET;
      s_reg.customer_id_byte1 <= CUST_ID_RESET;
      s_reg.customer_id_byte2 <= CUST_ID_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign byte_out = s_reg.out;
  assign mode = s_reg.mode;
  assign raw_active = s_reg.busy;
  assign customer_id = {s_reg.customer_id_byte2, s_reg.customer_id_byte1,
                        s_reg.customer_id_byte0};
  assign gain_b = s_reg.gain_b;
  assign gain_t = s_reg.gain_t;
  assign frame_dropped = s_reg.dropped;

  // ****************************************
  // Checks
  // ****************************************
  raw_entry_a: assert property (@(posedge clk) disable iff (srst)
    (s_reg.mode != MODE_RAW) ##1 (s_reg.mode == MODE_RAW) |->
    $past(s_reg.mode) == MODE_COMMAND)
    else $error("raw mode entered without command mode");
  cmd_entry_a: assert property (@(posedge clk) disable iff (srst)
    (cmd_in.valid && s_reg.mode == MODE_NORMAL && cmd_in.cmd == CMD_ENTER_COMMAND_MODE_CMD &&
     cmd_in.dat == DAT_ENTER_COMMAND_MODE_CMD) |=> s_reg.mode == MODE_COMMAND)
    else $error("command pair ignored");
  normal_exit_a: assert property (@(posedge clk) disable iff (srst)
    (cmd_in.valid && s_reg.mode != MODE_NORMAL && cmd_in.cmd == CMD_MODE &&
     cmd_in.dat == DAT_ENTER_NORMAL_MODE_CMD) |=> s_reg.mode == MODE_NORMAL)
    else $error("normal pair ignored");
  gated_raw_a: assert property (@(posedge clk) disable iff (srst)
    $rose(s_reg.busy) |-> $past(raw_stream))
    else $error("frame started without unity gains");
  frame_order_a: assert property (@(posedge clk) disable iff (srst)
    (s_reg.busy && s_reg.idx == 2'h0 && fifo_in_ready) |=>
    s_reg.idx == 2'h1 || s_reg.mode != MODE_RAW)
    else $error("frame byte order broken");
  high_zero_a: assert property (@(posedge clk) disable iff (srst)
    (s_reg.busy && s_reg.idx == 2'h0) |-> push_data[7:6] == 2'b00)
    else $error("bridge high byte top bits set");
  temp_low_a: assert property (@(posedge clk) disable iff (srst)
    (meas_in.valid && raw_stream && !s_reg.busy) |=>
    s_reg.temp == $past(meas_in.temp[7:0]))
    else $error("temperature byte not low bits");
  id_write_a: assert property (@(posedge clk) disable iff (srst)
    (cmd_in.valid && s_reg.mode == MODE_COMMAND && cmd_in.cmd == CMD_CUSTOMER_ID_BYTE1) |=>
    s_reg.customer_id_byte1 == $past(cmd_in.dat))
    else $error("customer id byte not stored");
  serial_only_a: assert property (@(posedge clk) disable iff (srst)
    !cmd_in.valid |=> $stable(s_reg.gain_b) && $stable(s_reg.customer_id_byte0))
    else $error("configuration changed without command");
  frame_start_a: assert property (@(posedge clk) disable iff (srst)
    (meas_in.valid && raw_stream && !s_reg.busy) |=> s_reg.busy && s_reg.idx == 2'h0)
    else $error("measurement did not start a frame");

  // ****************************************
  // Refusals, holding and coefficient writes
  // ****************************************
  drop_pulse_a: assert property (@(posedge clk) disable iff (srst)
    (meas_in.valid && raw_stream && s_reg.busy) |=> s_reg.dropped)
    else $error("overlapping measurement not flagged");
  frame_end_a: assert property (@(posedge clk) disable iff (srst)
    (s_reg.busy && s_reg.idx == FRAME_LAST && fifo_in_ready) |=> !s_reg.busy)
    else $error("frame did not end after temperature byte");
  raw_exit_a: assert property (@(posedge clk) disable iff (srst)
    (s_reg.mode == MODE_RAW) ##1 (s_reg.mode != MODE_RAW) |-> !s_reg.busy)
    else $error("frame kept running after raw mode ended");
  out_hold_a: assert property (@(posedge clk) disable iff (srst)
    (s_reg.out.valid && !byte_ready) |=> s_reg.out.valid && $stable(s_reg.out.data))
    else $error("output byte changed before it was taken");
  temp_sent_a: assert property (@(posedge clk) disable iff (srst)
    (s_reg.busy && s_reg.idx == FRAME_LAST) |-> push_data == s_reg.temp)
    else $error("third frame byte is not the temperature byte");
  no_corr_raw_a: assert property (@(posedge clk) disable iff (srst)
    (s_reg.mode == MODE_RAW && !s_reg.busy) |-> !push_valid)
    else $error("corrected byte queued in raw mode");
  raw_refuse_a: assert property (@(posedge clk) disable iff (srst)
    (cmd_in.valid && s_reg.mode == MODE_NORMAL && cmd_in.cmd == CMD_MODE &&
     cmd_in.dat == DAT_ENTER_RAW_MODE_CMD) |=> s_reg.mode == MODE_NORMAL)
    else $error("raw mode entered from normal mode");
  cmd_reentry_a: assert property (@(posedge clk) disable iff (srst)
    (cmd_in.valid && s_reg.mode == MODE_RAW && cmd_in.cmd == CMD_ENTER_COMMAND_MODE_CMD &&
     cmd_in.dat == DAT_ENTER_COMMAND_MODE_CMD) |=> s_reg.mode == MODE_COMMAND)
    else $error("command pair ignored in raw mode");
  normal_lock_a: assert property (@(posedge clk) disable iff (srst)
    (cmd_in.valid && s_reg.mode == MODE_NORMAL) |=>
    $stable(s_reg.customer_id_byte2) && $stable(s_reg.gain_t))
    else $error("configuration changed in normal mode");
  id_zero_a: assert property (@(posedge clk) disable iff (srst)
    (cmd_in.valid && s_reg.mode == MODE_COMMAND && cmd_in.cmd == CMD_CUSTOMER_ID_BYTE0) |=>
    s_reg.customer_id_byte0 == $past(cmd_in.dat))
    else $error("customer id byte zero not stored");
  id_two_a: assert property (@(posedge clk) disable iff (srst)
    (cmd_in.valid && s_reg.mode == MODE_COMMAND && cmd_in.cmd == CMD_CUSTOMER_ID_BYTE2) |=>
    s_reg.customer_id_byte2 == $past(cmd_in.dat))
    else $error("customer id byte two not stored");
  gain_high_a: assert property (@(posedge clk) disable iff (srst)
    (cmd_in.valid && s_reg.mode == MODE_COMMAND && cmd_in.cmd == CMD_GAIN_B_HI) |=>
    s_reg.gain_b[14:8] == $past(cmd_in.dat[6:0]))
    else $error("bridge gain upper part not stored");
  gain_low_a: assert property (@(posedge clk) disable iff (srst)
    (cmd_in.valid && s_reg.mode == MODE_COMMAND && cmd_in.cmd == CMD_GAIN_B_LO) |=>
    s_reg.gain_b[7:0] == $past(cmd_in.dat))
    else $error("bridge gain lower part not stored");
  gain_temp_a: assert property (@(posedge clk) disable iff (srst)
    (cmd_in.valid && s_reg.mode == MODE_COMMAND && cmd_in.cmd == CMD_GAIN_T) |=>
    s_reg.gain_t == $past(cmd_in.dat))
    else $error("temperature gain not stored");
  reset_state_a: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> s_reg.mode == MODE_NORMAL && !s_reg.out.valid && !s_reg.busy)
    else $error("state not cleared by reset");
endmodule

// ==== hdl/raw_readout_pkg.sv ====
// Shared constants and types for the raw-mode calibration readout
package raw_readout_pkg;

  // ****************************************
  // Command/data pairs
  // ****************************************
  localparam logic [7:0] CMD_ENTER_COMMAND_MODE_CMD = 8'h50;
  localparam logic [7:0] DAT_ENTER_COMMAND_MODE_CMD = 8'h90;
  localparam logic [7:0] CMD_MODE = 8'h40;
  localparam logic [7:0] DAT_ENTER_RAW_MODE_CMD = 8'h10;
  localparam logic [7:0] DAT_ENTER_NORMAL_MODE_CMD = 8'h00;
  localparam logic [7:0] CMD_GAIN_B_HI = 8'h80;
  localparam logic [7:0] CMD_GAIN_B_LO = 8'h90;
  localparam logic [7:0] CMD_GAIN_T = 8'hc0;
  localparam logic [7:0] CMD_CUSTOMER_ID_BYTE0 = 8'h28;
  localparam logic [7:0] CMD_CUSTOMER_ID_BYTE1 = 8'h38;
  localparam logic [7:0] CMD_CUSTOMER_ID_BYTE2 = 8'h48;

  // ****************************************
  // Coefficient values and reset values
  // ****************************************
  localparam logic [14:0] GAIN_B_UNITY = 15'h0800;
  localparam logic [7:0] GAIN_T_UNITY = 8'h80;
  localparam logic [14:0] GAIN_B_RESET = 15'h0000;
  localparam logic [7:0] GAIN_T_RESET = 8'h00;
  localparam logic [7:0] CUST_ID_RESET = 8'h00;

  // ****************************************
  // Frame layout and buffering
  // ****************************************
  localparam int BRIDGE_W = 14;
  localparam int TEMP_W = 11;
  localparam int TEMP_SENT_W = 8;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [1:0] FRAME_LAST = 2'h2;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_COMMAND = 2'b01,
    MODE_RAW = 2'b11
  } mode_t;

  typedef struct packed {
    logic valid;
    logic [7:0] cmd;
    logic [7:0] dat;
  } cmd_pair_t;

  typedef struct packed {
    logic valid;
    logic [BRIDGE_W-1:0] bridge;
    logic [TEMP_W-1:0] temp;
  } meas_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_out_t;

endpackage

// ==== hdl/byte_fifo.sv ====
// Parameterised valid/ready FIFO in flip-flops
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_state_t;

  fifo_state_t st_reg, st_next;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic push, pop;

  assign in_ready = (st_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.cnt != '0);
  assign out_data = mem_reg[st_reg.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr = st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = st_reg.rd + 1'b1;
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
    if (push) begin
      mem_reg[st_reg.wr] <= in_data;
    end
  end
endmodule

// ==== sim/byte_sink.sv ====
// Byte consumer standing in for the serial pin driver
`timescale 1ns/10ps
module byte_sink (
  input wire logic clk,
  input wire logic stall,
  input wire raw_readout_pkg::byte_out_t byte_out,
  output logic byte_ready
);
  logic [7:0] got[$];
  initial byte_ready = 1'b0;
  // ****************************************
  // Capture with random back-pressure
  // ****************************************
  // Slow and prompt acceptance both occur, so bytes must hold until taken
  always @(posedge clk) begin
    if (byte_out.valid === 1'b1 && byte_ready === 1'b1) begin
      got.push_back(byte_out.data);
    end
    #1 byte_ready = !stall && ($urandom % 3 != 0);
  end
endmodule

// ==== sim/raw_readout_tb.sv ====
// Self-checking bench for the raw-mode calibration readout
`timescale 1ns/10ps
module raw_readout_tb;
  import raw_readout_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  cmd_pair_t cmd_in = '0;
  meas_t meas_in = '0;
  logic corr_valid = 1'b0;
  logic [7:0] corr_data = 8'h00;
  byte_out_t byte_out;
  mode_t mode;
  logic byte_ready, raw_active, frame_dropped;
  logic stall = 1'b1;
  logic [23:0] customer_id;
  logic [14:0] gain_b;
  logic [7:0] gain_t;
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int checked = 0;

  always #10 clk = ~clk;

  raw_readout u_dut (.clk(clk), .srst(srst), .cmd_in(cmd_in), .meas_in(meas_in),
    .corr_valid(corr_valid), .corr_data(corr_data), .byte_out(byte_out),
    .byte_ready(byte_ready), .mode(mode), .raw_active(raw_active),
    .customer_id(customer_id), .gain_b(gain_b), .gain_t(gain_t),
    .frame_dropped(frame_dropped));

  byte_sink u_sink (.clk(clk), .stall(stall), .byte_out(byte_out), .byte_ready(byte_ready));

  // ****************************************
  // Reporting and drivers
  // ****************************************
  task automatic print_verdict;
    $display("checked %0d, n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic timed_out(input string what);
    n_errors++;
    $display("unexpected at %0t: timeout on %s", $time, what);
    print_verdict();
  endtask

  task automatic send_cmd(input logic [7:0] c, input logic [7:0] d);
    cmd_in = '{1'b1, c, d};
    @(posedge clk);
    #1 cmd_in = '0;
    @(posedge clk);
    #1;
  endtask

  task automatic pulse_meas(input logic [13:0] br, input logic [10:0] tp);
    meas_in = '{1'b1, br, tp};
    @(posedge clk);
    #1 meas_in.valid = 1'b0;
  endtask

  // Expected frame: bridge high with top bits cleared, bridge low, low temperature bits
  function automatic void push_frame(input logic [13:0] br, input logic [10:0] tp);
    exp_q.push_back({2'b00, br[13:8]});
    exp_q.push_back(br[7:0]);
    exp_q.push_back(tp[7:0]);
  endfunction

  task automatic send_meas(input logic [13:0] br, input logic [10:0] tp);
    int i;
    for (i = 0; i < 60 && raw_active !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 60) timed_out("frame idle");
    pulse_meas(br, tp);
    push_frame(br, tp);
  endtask

  task automatic drain;
    int i;
    stall = 1'b0;
    for (i = 0; i < 400 && u_sink.got.size() < exp_q.size(); i++) @(posedge clk);
    repeat (10) @(posedge clk);
    #1 stall = 1'b1;
    check(u_sink.got.size(), exp_q.size(), "byte count");
    foreach (exp_q[k]) begin
      if (k < u_sink.got.size()) check(u_sink.got[k], exp_q[k], "stream byte");
    end
    exp_q.delete();
    u_sink.got.delete();
  endtask

  // Calibration point: master drops the first frame and averages sixteen
  task automatic cal_point;
    int i;
    int sum_b;
    int sum_t;
    int got_b;
    int got_t;
    logic [13:0] br;
    logic [10:0] tp;
    sum_b = 0;
    sum_t = 0;
    got_b = 0;
    got_t = 0;
    @(posedge clk);
    #1 stall = 1'b0;
    for (i = 0; i < 17; i++) begin
      br = 14'($urandom);
      tp = 11'($urandom);
      send_meas(br, tp);
      if (i > 0) begin
        sum_b += br;
        sum_t += tp[7:0];
      end
    end
    for (i = 0; i < 400 && u_sink.got.size() < exp_q.size(); i++) @(posedge clk);
    for (i = 3; i + 2 < u_sink.got.size(); i += 3) begin
      got_b += {u_sink.got[i][5:0], u_sink.got[i + 1]};
      got_t += u_sink.got[i + 2];
    end
    check(24'(got_b / 16), 24'(sum_b / 16), "bridge average");
    check(24'(got_t / 16), 24'(sum_t / 16), "temperature average");
    drain();
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int i;
    logic [7:0] id0, id1, id2;
    logic [13:0] br;
    logic [10:0] tp;
    void'($urandom(29));
    repeat (4) @(posedge clk);
    #1 srst = 1'b0;
    check(mode, MODE_NORMAL, "reset mode");
    check({gain_b, gain_t}, {GAIN_B_RESET, GAIN_T_RESET}, "reset gains");
    check(customer_id, {3{CUST_ID_RESET}}, "reset id");
    $display("test reset done");
    send_cmd(CMD_MODE, DAT_ENTER_RAW_MODE_CMD);
    check(mode, MODE_NORMAL, "raw without command");
    send_cmd(CMD_CUSTOMER_ID_BYTE0, 8'h5a);
    check(customer_id, {3{CUST_ID_RESET}}, "program in normal");
    send_cmd(CMD_ENTER_COMMAND_MODE_CMD, DAT_ENTER_COMMAND_MODE_CMD);
    check(mode, MODE_COMMAND, "command entry");
    id0 = $urandom;
    id1 = $urandom;
    id2 = $urandom;
    send_cmd(CMD_CUSTOMER_ID_BYTE0, id0);
    send_cmd(CMD_CUSTOMER_ID_BYTE1, id1);
    send_cmd(CMD_CUSTOMER_ID_BYTE2, id2);
    check(customer_id, {id2, id1, id0}, "customer id");
    send_cmd(CMD_GAIN_B_HI, {1'b0, GAIN_B_UNITY[14:8]});
    send_cmd(CMD_GAIN_B_LO, GAIN_B_UNITY[7:0]);
    send_cmd(CMD_GAIN_T, GAIN_T_UNITY);
    check({gain_b, gain_t}, {GAIN_B_UNITY, GAIN_T_UNITY}, "unity gains");
    send_cmd(CMD_MODE, DAT_ENTER_RAW_MODE_CMD);
    check(mode, MODE_RAW, "raw entry");
    $display("test command sequence done");
    // Six frames with the sink stalled: overflows the buffer, sequencer must wait
    for (i = 0; i < 6; i++) begin
      br = (i == 0) ? 14'h3fff : 14'($urandom);
      tp = (i == 1) ? 11'h7ff : 11'($urandom);
      send_meas(br, tp);
      if (i == 2) begin
        @(posedge clk);
        #1 pulse_meas(14'h0001, 11'h001);
        for (int j = 0; j < 4 && frame_dropped !== 1'b1; j++) @(posedge clk);
        check(frame_dropped, 1'b1, "drop pulse");
        #1 corr_data = 8'ha5;
        corr_valid = 1'b1;
        @(posedge clk);
        #1 corr_valid = 1'b0;
      end
    end
    drain();
    $display("test raw stream done");
    for (i = 0; i < 2; i++) cal_point();
    // Coefficients are written only once every point is collected
    send_cmd(CMD_GAIN_B_HI, 8'h0c);
    send_cmd(CMD_GAIN_B_LO, 8'h34);
    check(gain_b, 15'h0c34, "coefficient write");
    pulse_meas(14'h0abc, 11'h123);
    check(raw_active, 1'b0, "raw frame without unity gain");
    $display("test calibration done");
    send_cmd(CMD_MODE, DAT_ENTER_NORMAL_MODE_CMD);
    check(mode, MODE_NORMAL, "normal return");
    pulse_meas(14'h1234, 11'h456);
    corr_data = 8'h3c;
    corr_valid = 1'b1;
    @(posedge clk);
    #1 corr_valid = 1'b0;
    exp_q.push_back(8'h3c);
    drain();
    $display("test normal output done");
    print_verdict();
  end
endmodule
